// file: src/prs_params.svh
// Register offsets, reset values and pin codes of the pin remapping block.
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_ADR_REMAP     8'h00
`define PRS_ADR_WAKE      8'h04
`define PRS_ADR_ANALOG    8'h08
`define PRS_ADR_CONV      8'h0C
`define PRS_ADR_BITOP     8'h40
`define PRS_REG_DATA      4'h1
`define PRS_REG_DIR       4'h2
`define PRS_REG_PULL      4'h3
`define PRS_MASK_A        8'h3F
`define PRS_MASK_B        8'h7F
`define PRS_RST_PORT      32'hFFFFFFFF
`define PRS_RST_PULL      32'h00000000
`define PRS_RST_ANALOG    8'hFF
`define PRS_RST_REMAP     8'h00
`define PRS_RST_WAKE      8'h00
`define PRS_BOP_SET       7
`define PRS_SDO_UNDEF     2'h2
`define PRS_PA1           5'h01
`define PRS_PA3           5'h03
`define PRS_PB0           5'h08
`define PRS_PB1           5'h09
`define PRS_PB3           5'h0B
`define PRS_PB4           5'h0C
`define PRS_PB5           5'h0D
`define PRS_PB6           5'h0E
`define PRS_PC2           5'h12
`define PRS_PC3           5'h13
`define PRS_PC4           5'h14
`define PRS_PC5           5'h15
`define PRS_PC6           5'h16
`define PRS_PD1           5'h19
`define PRS_PD2           5'h1A
`define PRS_PD3           5'h1B
`endif

// file: src/prs_pkg.sv
// Types shared by the pin remapping block and its users.
package prs_pkg;
  typedef struct packed {
    logic val;
    logic en;
  } prs_fout_t;
  typedef logic [4:0] prs_pin_t;
endpackage

// file: src/prs_top.sv
// Pin remapping selection, port registers, analog defaults and Port A wake-up.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "prs_params.svh"

// How it works
// R1: When two functions drive one pin, the higher priority function wins.
// R2: Variant A bit 5 puts serial data out on PC2, or PA1 when set.
// R3: Variant A bit 4 puts serial data in on PC3, or PA3 when set.
// R4: Variant A bit 3 puts serial clock on PC4, or PB6 when set.
// R5: Variant A bit 2 puts chip select on PA1, or PB5 when set.
// R6: Variant A bit 1 takes interrupt B from PB1, or PC5 when set.
// R7: Variant A bits 7 and 6 do not exist and read zero.
// R8: Variant B bit 2 puts chip select on PC6, or PB5 when set.
// R9: Variant B bit 1 drives UART transmit on PD2, or PB3 when set.
// R10: Variant B bit 0 takes UART receive from PD1, or PB4 when set.
// R11: Reset sets all port data and direction bits to one.
// R12: A pin turned output without a data write drives high.
// R13: A bit set or clear reads the whole port and writes it back.
// R14: Reset leaves converter pins analog with the converter off.
// R15: Software removes the analog function before digital use of a pin.
// R16: An analog enabled pin never gets its pull-high.
// R17: In low power, a falling edge on an enabled Port A pin wakes.
// R18: A wake control bit of one enables wake-up for its pin.
// R19: Direction one is input; output pins read back their data latch.
// R20: A remap write takes effect on the following clock.
// R21: Variant B serial out code 10 drives no pin at all.
module prs_top import prs_pkg::*; #(
  parameter int VARIANT = 0
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Port pins, ports A to D at bytes 0 to 3.
  input  wire logic [31:0] pin_in_i,
  output logic      [31:0] pin_out_o,
  output logic      [31:0] pin_oe_n_o,
  output logic      [31:0] pull_en_o,
  output logic      [7:0]  analog_o,
  output logic             conv_on_o,
  // Peripheral side.
  input  prs_fout_t        serial_out_i,
  input  prs_fout_t        serial_data_i,
  input  prs_fout_t        serial_clock_i,
  input  prs_fout_t        serial_chip_select_i,
  input  prs_fout_t        uart_out_i,
  output logic             serial_in_o,
  output logic             serial_clock_o,
  output logic             serial_chip_select_o,
  output logic             ext_irq_a_o,
  output logic             ext_irq_b_o,
  output logic             uart_in_o,
  // Power management.
  input  wire logic        low_power_i,
  output logic             wake_o
);
  if (VARIANT < 0 || VARIANT > 1) begin : g_check
    $error("prs_top: VARIANT must be 0 or 1");
  end

  localparam bit VB = (VARIANT == 1);

  logic [7:0]  remap;
  logic [7:0]  wake_en;
  logic [7:0]  ana;
  logic        conv;
  logic [31:0] data;
  logic [31:0] dir;
  logic [31:0] pull;
  logic [31:0] pin_s1;
  logic [31:0] pin_s2;
  logic [7:0]  pa_prev;
  logic [31:0] nv;
  logic [31:0] nd;

  // Bus decode; the slave answers one cycle after the request is seen.
  wire         req      = wb_cyc_i & wb_stb_i;
  wire         commit   = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire [7:0]   wbyte    = wb_dat_i[7:0];
  wire [3:0]   region   = wb_adr_i[7:4];
  wire [31:0]  port_m   = 32'h000000FF << {wb_adr_i[3:2], 3'b000};
  wire         wr_remap = commit & (wb_adr_i == `PRS_ADR_REMAP);
  wire         wr_wake  = commit & (wb_adr_i == `PRS_ADR_WAKE);
  wire         wr_ana   = commit & (wb_adr_i == `PRS_ADR_ANALOG);
  wire         wr_conv  = commit & (wb_adr_i == `PRS_ADR_CONV);
  wire         wr_bop   = commit & (wb_adr_i == `PRS_ADR_BITOP);
  wire         wr_data  = commit & (region == `PRS_REG_DATA) & (wb_adr_i[1:0] == 2'h0);
  wire         wr_dir   = commit & (region == `PRS_REG_DIR) & (wb_adr_i[1:0] == 2'h0);
  wire         wr_pull  = commit & (region == `PRS_REG_PULL) & (wb_adr_i[1:0] == 2'h0);
  wire [7:0]   rmask    = VB ? `PRS_MASK_B : `PRS_MASK_A;

  // Analog pins give no digital level.
  wire [31:0]  din      = pin_s2 & ~{24'h000000, ana};
  // Input pins read the pin, output pins read the latch. [R19]
  wire [31:0]  port_rd  = (dir & din) | (~dir & data);

  function automatic logic [7:0] pick(input logic [31:0] v, input logic [1:0] p);
    pick = v[{p, 3'b000} +: 8];
  endfunction

  // Single bit set and clear work on the whole port byte. [R13]
  wire         bop_dir  = wbyte[4];
  wire [4:0]   bop_idx  = {wbyte[6:5], wbyte[2:0]};
  wire [31:0]  bop_one  = 32'h00000001 << bop_idx;
  wire [31:0]  bop_m    = 32'h000000FF << {wbyte[6:5], 3'b000};
  wire [31:0]  bop_base = bop_dir ? dir : port_rd;
  wire [31:0]  bop_res  = wbyte[`PRS_BOP_SET] ? (bop_base | bop_one) : (bop_base & ~bop_one);
  wire [31:0]  wfull    = {4{wbyte}};

  wire [31:0]  next_data = (wr_bop & !bop_dir) ? ((data & ~bop_m) | (bop_res & bop_m)) :
                           wr_data ? ((data & ~port_m) | (wfull & port_m)) : data;
  wire [31:0]  next_dir  = (wr_bop & bop_dir) ? ((dir & ~bop_m) | (bop_res & bop_m)) :
                           wr_dir ? ((dir & ~port_m) | (wfull & port_m)) : dir;
  wire [31:0]  next_pull = wr_pull ? ((pull & ~port_m) | (wfull & port_m)) : pull;
  // Unimplemented selection bits are never stored. [R7]
  wire [7:0]   next_remap = wr_remap ? (wbyte & rmask) : remap;

  wire [7:0]   rd_byte =
    (wb_adr_i == `PRS_ADR_REMAP)  ? remap :
    (wb_adr_i == `PRS_ADR_WAKE)   ? wake_en :
    (wb_adr_i == `PRS_ADR_ANALOG) ? ana :
    (wb_adr_i == `PRS_ADR_CONV)   ? {7'h00, conv} :
    (wb_adr_i[1:0] != 2'h0)       ? 8'h00 :
    (region == `PRS_REG_DATA)     ? pick(port_rd, wb_adr_i[3:2]) :
    (region == `PRS_REG_DIR)      ? pick(dir, wb_adr_i[3:2]) :
    (region == `PRS_REG_PULL)     ? pick(pull, wb_adr_i[3:2]) : 8'h00;

  // Routing follows the stored selection with no further trigger. [R20]
  wire [1:0]   sdo_f   = remap[6:5];
  wire         sdo_ok  = !VB || (sdo_f != `PRS_SDO_UNDEF); // [R21]
  wire prs_pin_t sdo_pin = VB ? ((sdo_f == 2'h0) ? `PRS_PC3 :
                                 (sdo_f == 2'h1) ? `PRS_PA1 : `PRS_PD3) :
                           (remap[5] ? `PRS_PA1 : `PRS_PC2); // [R2]
  wire prs_pin_t sda_pin = remap[4] ? `PRS_PA3 : (VB ? `PRS_PC4 : `PRS_PC3); // [R3]
  wire prs_pin_t sck_pin = remap[3] ? `PRS_PB6 : (VB ? `PRS_PC5 : `PRS_PC4); // [R4]
  wire prs_pin_t scs_pin = remap[2] ? `PRS_PB5 : (VB ? `PRS_PC6 : `PRS_PA1); // [R5] [R8]
  wire prs_pin_t irqb_pin = (!VB && remap[1]) ? `PRS_PC5 : `PRS_PB1; // [R6]
  wire prs_pin_t irqa_pin = (!VB && remap[0]) ? `PRS_PC6 : `PRS_PB0;
  wire prs_pin_t tx_pin  = remap[1] ? `PRS_PB3 : `PRS_PD2; // [R9]
  wire prs_pin_t rx_pin  = remap[0] ? `PRS_PB4 : `PRS_PD1; // [R10]

  // Later overlays win, so the function named rightmost on a pin prevails. [R1]
  always_comb begin
    nv = data;
    nd = ~dir;
    if (serial_clock_i.en) begin
      nv[sck_pin] = serial_clock_i.val;
      nd[sck_pin] = 1'b1;
    end
    if (serial_data_i.en) begin
      nv[sda_pin] = serial_data_i.val;
      nd[sda_pin] = 1'b1;
    end
    if (serial_chip_select_i.en) begin
      nv[scs_pin] = serial_chip_select_i.val;
      nd[scs_pin] = 1'b1;
    end
    if (serial_out_i.en && sdo_ok) begin
      nv[sdo_pin] = serial_out_i.val;
      nd[sdo_pin] = 1'b1;
    end
    if (VB && uart_out_i.en) begin
      nv[tx_pin] = uart_out_i.val;
      nd[tx_pin] = 1'b1;
    end
  end

  // Port A falling edges on wake-enabled pins. [R17] [R18]
  wire [7:0]   fall = pa_prev & ~pin_s2[7:0] & wake_en;

  always_ff @(posedge clk_i) begin
    pin_s1  <= pin_in_i;
    pin_s2  <= pin_s1;
    pa_prev <= pin_s2[7:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & !wb_ack_o;
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // Ports come up as inputs with latches high, so a new output drives high. [R11] [R12]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data    <= `PRS_RST_PORT;
      dir     <= `PRS_RST_PORT;
      pull    <= `PRS_RST_PULL;
      remap   <= `PRS_RST_REMAP;
      wake_en <= `PRS_RST_WAKE;
      ana     <= `PRS_RST_ANALOG; // [R14]
      conv    <= 1'b0; // [R14]
    end else begin
      data    <= next_data;
      dir     <= next_dir;
      pull    <= next_pull;
      remap   <= next_remap;
      wake_en <= wr_wake ? wbyte : wake_en;
      ana     <= wr_ana ? wbyte : ana;
      conv    <= wr_conv ? wbyte[0] : conv;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o            <= `PRS_RST_PORT;
      pin_oe_n_o           <= `PRS_RST_PORT;
      pull_en_o            <= `PRS_RST_PULL;
      analog_o             <= `PRS_RST_ANALOG;
      conv_on_o            <= 1'b0;
      serial_in_o          <= 1'b0;
      serial_clock_o       <= 1'b0;
      serial_chip_select_o <= 1'b0;
      ext_irq_a_o          <= 1'b0;
      ext_irq_b_o          <= 1'b0;
      uart_in_o            <= 1'b0;
      wake_o               <= 1'b0;
    end else begin
      pin_out_o            <= nv;
      pin_oe_n_o           <= ~nd;
      pull_en_o            <= pull & dir & ~{24'h000000, ana}; // [R16]
      analog_o             <= ana;
      conv_on_o            <= conv;
      serial_in_o          <= din[sda_pin];
      serial_clock_o       <= din[sck_pin];
      serial_chip_select_o <= din[scs_pin];
      ext_irq_a_o          <= din[irqa_pin];
      ext_irq_b_o          <= din[irqb_pin];
      uart_in_o            <= din[rx_pin];
      wake_o               <= low_power_i & (|fall); // [R17]
    end
  end

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  port_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    $past(rst_i) |-> (data == `PRS_RST_PORT) && (dir == `PRS_RST_PORT) && (pin_oe_n_o == '1))
    else $error("ports not inputs after reset");
  remap_upper_a: assert property (@(posedge clk_i) // [R7]
    !VB |-> remap[7:6] == 2'h0) else $error("unimplemented remap bits set");
  remap_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    wr_remap |=> remap == ($past(wbyte) & rmask)) else $error("remap write lost");
  sdo_default_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (!VB && !remap[5] && serial_out_i.en) |=> !pin_oe_n_o[`PRS_PC2]
      && pin_out_o[`PRS_PC2] == $past(serial_out_i.val)) else $error("serial out not on PC2");
  tx_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (VB && remap[1] && uart_out_i.en) |=> !pin_oe_n_o[`PRS_PB3]
      && pin_out_o[`PRS_PB3] == $past(uart_out_i.val)) else $error("transmit not on PB3");
  pull_analog_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    (ana != 8'h00) |=> (pull_en_o[7:0] & $past(ana)) == 8'h00) else $error("pull on analog pin");
  wake_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (low_power_i && (fall != 8'h00)) |=> wake_o) else $error("missed wake edge");
  bop_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (wr_bop && bop_dir) |=> (dir & ~$past(bop_one)) == ($past(dir) & ~$past(bop_one)))
    else $error("bit op changed other bits");
  read_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    (req && !wb_ack_o && !wb_we_i && region == `PRS_REG_DATA && wb_adr_i[1:0] == 2'h0
     && pick(dir, wb_adr_i[3:2]) == 8'h00) |=> wb_dat_o[7:0] == pick($past(data), $past(wb_adr_i[3:2])))
    else $error("output read not from latch");
endmodule

// file: verification/prs_pins_model.sv
// Package pins as the outside world sees them.
`timescale 1ns/1ps
module prs_pins_model (
  // Design side.
  input  wire logic [31:0] pin_out_i,
  input  wire logic [31:0] pin_oe_n_i,
  input  wire logic [31:0] pull_en_i,
  // Outside world.
  input  wire logic [31:0] ext_i,
  output logic      [31:0] level_o
);
  // A driven pin shows its drive; a released pin reads the pull-high or the outside level.
  // The bench never leaves a released pin undriven, so no stale level can leak through.
  assign level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & (pull_en_i | ext_i));
endmodule

// file: verification/pin_remap_select_test.sv
// Self-checking bench for the pin remapping block, both variants on one bus.
`timescale 1ns/1ps
`include "prs_params.svh"
module pin_remap_select_test import prs_pkg::*;;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, low_power = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, ext = 32'hFFFFFFFF, seed = 32'h0000005B;
  logic [31:0] rdat, pin_out, pin_oe_n, pull_en, level;
  logic [7:0]  analog;
  logic        ack, conv_on, ser_in, ser_clk, cs_o, irq_a, irq_b, uart_in, wake;
  prs_fout_t   sdo = '0, serial_chip_select = '0, uo = '0;
  logic [31:0] pin_out_b, pin_oe_n_b, pull_en_b, level_b;
  logic        uart_in_b;
  int          fails = 0, total_checks = 0;

  always #20 clk_i = ~clk_i;

  prs_top #(.VARIANT(0)) u_prs_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_in_i(level), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .pull_en_o(pull_en),
    .analog_o(analog), .conv_on_o(conv_on), .serial_out_i(sdo), .serial_data_i('0),
    .serial_clock_i('0), .serial_chip_select_i(serial_chip_select), .uart_out_i('0),
    .serial_in_o(ser_in), .serial_clock_o(ser_clk), .serial_chip_select_o(cs_o),
    .ext_irq_a_o(irq_a), .ext_irq_b_o(irq_b), .uart_in_o(uart_in),
    .low_power_i(low_power), .wake_o(wake));

  prs_pins_model u_prs_pins_model (.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
    .pull_en_i(pull_en), .ext_i(ext), .level_o(level));

  // Variant B shares the bus; its acknowledge mirrors variant A and is left unread.
  prs_top #(.VARIANT(1)) u_prs_top_b (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(), .wb_ack_o(),
    .pin_in_i(level_b), .pin_out_o(pin_out_b), .pin_oe_n_o(pin_oe_n_b),
    .pull_en_o(pull_en_b), .analog_o(), .conv_on_o(), .serial_out_i(sdo),
    .serial_data_i('0), .serial_clock_i('0), .serial_chip_select_i(serial_chip_select), .uart_out_i(uo),
    .serial_in_o(), .serial_clock_o(), .serial_chip_select_o(),
    .ext_irq_a_o(), .ext_irq_b_o(), .uart_in_o(uart_in_b),
    .low_power_i(low_power), .wake_o());

  prs_pins_model u_prs_pins_model_b (.pin_out_i(pin_out_b), .pin_oe_n_i(pin_oe_n_b),
    .pull_en_i(pull_en_b), .ext_i(ext), .level_o(level_b));

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int pick(input logic s, input prs_pin_t a, input prs_pin_t b);
    return s ? int'(b) : int'(a);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h000000, e});
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The whole sequence needs about two hundred cycles; this margin only catches a hang.
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    logic        v, seen;
    int          sp, cp;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 4; p++) rd_chk(8'h20 + 8'(4 * p), 8'hFF);
    check(pin_oe_n, 32'hFFFFFFFF);
    check(32'(analog), 32'h000000FF);
    check(32'(conv_on), 32'h0);
    $display("Reset test done.");
    wr(8'h24, 8'h00);
    repeat (2) @(posedge clk_i);
    check(32'(pin_out[15:8]), 32'h000000FF);
    check(32'(pin_oe_n[15:8]), 32'h0);
    rd_chk(8'h14, 8'hFF);
    wr(8'h24, 8'hFF);
    wr(`PRS_ADR_BITOP, 8'h53);
    rd_chk(8'h28, 8'hF7);
    wr(`PRS_ADR_BITOP, 8'hD3);
    rd_chk(8'h28, 8'hFF);
    wr(`PRS_ADR_REMAP, 8'hFF);
    rd_chk(`PRS_ADR_REMAP, 8'h3F);
    $display("Register test done.");
    wr(8'h30, 8'hFF);
    repeat (2) @(posedge clk_i);
    check(32'(pull_en[7:0]), 32'h0);
    wr(`PRS_ADR_ANALOG, 8'h00);
    repeat (2) @(posedge clk_i);
    check(32'(pull_en[7:0]), 32'hFF);
    wr(8'h30, 8'h00);
    for (int i = 0; i < 12; i++) begin
      r = next_rand();
      v = r[8];
      ext <= next_rand();
      sdo <= '{val: v, en: 1'b1};
      serial_chip_select <= '{val: ~v, en: 1'b1};
      uo  <= '{val: v, en: 1'b1};
      wr(`PRS_ADR_REMAP, {2'b00, r[5:0]});
      repeat (5) @(posedge clk_i);
      sp = pick(r[5], `PRS_PC2, `PRS_PA1);
      cp = pick(r[2], `PRS_PA1, `PRS_PB5);
      check(32'(pin_out[sp]), 32'(v));
      check(32'(pin_out[cp]), 32'((cp == sp) ? v : !v));
      check(32'(cs_o), 32'((cp == sp) ? v : !v));
      check(32'(irq_a), 32'(ext[pick(r[0], `PRS_PB0, `PRS_PC6)]));
      check(32'(ser_in), 32'(ext[pick(r[4], `PRS_PC3, `PRS_PA3)]));
      check(32'(ser_clk), 32'(ext[pick(r[3], `PRS_PC4, `PRS_PB6)]));
      check(32'(irq_b), 32'(ext[pick(r[1], `PRS_PB1, `PRS_PC5)]));
      check(32'(pin_out_b[pick(r[2], `PRS_PC6, `PRS_PB5)]), 32'(!v));
      check(32'(pin_out_b[pick(r[1], `PRS_PD2, `PRS_PB3)]), 32'(v));
      check(32'(uart_in_b), 32'(ext[pick(r[0], `PRS_PD1, `PRS_PB4)]));
    end
    // The undefined serial out code must leave all three candidate pins released.
    wr(`PRS_ADR_REMAP, 8'h40);
    repeat (2) @(posedge clk_i);
    check(32'({pin_oe_n_b[`PRS_PC3], pin_oe_n_b[`PRS_PA1], pin_oe_n_b[`PRS_PD3]}), 32'h7);
    $display("Routing test done.");
    sdo <= '0;
    serial_chip_select <= '0;
    uo  <= '0;
    ext <= 32'hFFFFFFFF;
    wr(`PRS_ADR_WAKE, 8'h01);
    low_power <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < 2; k++) begin
      ext <= k ? 32'hFFFFFFFC : 32'hFFFFFFFE;
      seen = 1'b0;
      repeat (10) begin
        @(posedge clk_i);
        if (wake === 1'b1) seen = 1'b1;
      end
      check(32'(seen), 32'(k == 0));
    end
    $display("Wake test done.");
    close_out();
  end
endmodule
